/* verilog/rtceac_pkg.sv */
// constants and types for the rtc error adjust, capture and interrupt block
package rtceac_pkg;
  localparam int unsigned PRESC_CYCLES   = 32768;
  localparam logic [16:0] PRESC_CYCLES_W = 17'h08000;
  localparam logic [14:0] PRESC_RESET    = 15'h0000;
  // seconds per automatic adjustment period
  localparam logic [5:0]  PERIOD_MINUTE  = 6'h3c;
  localparam logic [5:0]  PERIOD_TEN_SEC = 6'h0a;
  localparam logic [5:0]  PERIOD_EIGHT   = 6'h08;
  // filter sample dividers, in counting-source cycles, and filter times in ms
  localparam logic [12:0] DIV_32_MASK    = 13'h001f;
  localparam logic [12:0] DIV_4096_MASK  = 13'h0fff;
  localparam logic [12:0] DIV_8192_MASK  = 13'h1fff;
  localparam int unsigned FILT_250_MS    = 250;
  localparam int unsigned FILT_500_MS    = 500;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL_TWO    = 8'h00;
  localparam logic [7:0] OFS_ADJUST      = 8'h04;
  localparam logic [7:0] OFS_CTRL_THREE  = 8'h08;
  localparam logic [7:0] OFS_FILT_EN     = 8'h0c;
  localparam logic [7:0] OFS_CAP_CTRL0   = 8'h10;
  localparam logic [7:0] OFS_PERIODIC    = 8'h1c;
  localparam logic [7:0] OFS_IRQ_FLAGS   = 8'h20;
  localparam logic [7:0] OFS_PRESC       = 8'h24;
  localparam logic [7:0] OFS_CAP_DATA0   = 8'h40;
  // field positions
  localparam int unsigned BIT_AUTO_EN    = 0;
  localparam int unsigned BIT_AUTO_PER   = 1;
  localparam int unsigned BIT_CNT_MODE   = 2;
  localparam int unsigned BIT_CAP_STATUS = 7;
  localparam int unsigned FILT_HIGH_POS  = 4;
  // adjustment direction codes
  localparam logic [1:0] DIR_NONE = 2'h0;
  localparam logic [1:0] DIR_ADD  = 2'h1;
  localparam logic [1:0] DIR_SUB  = 2'h2;
  // capture filter select codes
  localparam logic [1:0] CFS_OFF_OR_SLOW = 2'h0;
  localparam logic [1:0] CFS_SOURCE      = 2'h2;
  localparam logic [1:0] CFS_DIV32       = 2'h3;
  // periodic interval codes and bus response codes
  localparam logic [3:0] PIS_256TH = 4'h6;
  localparam logic [3:0] PIS_TWO_S = 4'hf;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } rtceac_cal_t;

  typedef struct packed {
    logic [1:0] direction;
    logic [5:0] amount;
  } rtceac_adj_t;
endpackage

/* verilog/rtceac_top.sv */
// rtc time error adjustment, time capture and interrupt requests
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
// Overview of operation
// [RULE1] prescaler counts 32768 source cycles per second
// [RULE2] auto-adjust bit selects automatic or software
// [RULE3] automatic mode adjusts prescaler each period
// [RULE4] calendar: period bit 0 minute, 1 ten seconds
// [RULE5] binary mode: period bit 1 gives eight seconds
// [RULE6] direction 00 none, 01 add, 10 subtract
// [RULE7] six-bit amount gives cycles per correction
// [RULE8] software mode adjusts when register is written
// [RULE9] each later write adjusts once more
// [RULE10] software clears direction before changing mode
// [RULE11] direction 00 stops all further correction
// [RULE12] capture edge stores calendar or binary counters
// [RULE13] filter accepts level after three matching samples
// [RULE14] filtered capture sets the status bit
// [RULE15] each capture input has its own filter
// [RULE16] filter choices: off, 2^12, 2^13, 32, undivided
// [RULE17] capture enable low ignores capture pins
// [RULE18] two alarm requests and one periodic request
// [RULE19] alarm flag rearms only after new match
// [RULE20] software clears alarm flag after alarm rewrite
// [RULE21] periodic interval from 2 s to 1/256 s
// [RULE22] filter enable register reset only by power-on
// [RULE23] 2^12 divide is 250 ms, 2^13 500 ms
// [RULE24] filter off captures first synchronized active edge
module rtceac_top (
  input  wire logic                      SYS_CLK,
  input  wire logic                      RESET_N,
  input  wire logic                      RTC_POR_N,
  input  wire logic                      CLK_EN,
  input  wire logic                      SUB_TICK,
  input  wire rtceac_pkg::rtceac_cal_t   CAL_COUNT,
  input  wire logic [31:0]               BIN_COUNT,
  input  wire logic [2:0]                CAPTURE_EVENT_INPUT,
  input  wire logic [1:0]                ALARM_MATCH,
  input  wire logic [1:0]                ALARM_REWRITE,
  input  wire logic [7:0]                S_AXI_AWADDR,
  input  wire logic                      S_AXI_AWVALID,
  output logic                           S_AXI_AWREADY,
  input  wire logic [31:0]               S_AXI_WDATA,
  input  wire logic [3:0]                S_AXI_WSTRB,
  input  wire logic                      S_AXI_WVALID,
  output logic                           S_AXI_WREADY,
  output logic [1:0]                     S_AXI_BRESP,
  output logic                           S_AXI_BVALID,
  input  wire logic                      S_AXI_BREADY,
  input  wire logic [7:0]                S_AXI_ARADDR,
  input  wire logic                      S_AXI_ARVALID,
  output logic                           S_AXI_ARREADY,
  output logic [31:0]                    S_AXI_RDATA,
  output logic [1:0]                     S_AXI_RRESP,
  output logic                           S_AXI_RVALID,
  input  wire logic                      S_AXI_RREADY,
  output logic                           SECOND_PULSE,
  output logic [14:0]                    PRESC_COUNT,
  output logic [1:0]                     ALARM_IRQ,
  output logic                           PERIODIC_IRQ
);
  localparam int NCAP = 3;

  // registers written by software
  logic                    auto_adjust_enable_r, auto_adjust_period_r, count_mode_select_r;
  rtceac_pkg::rtceac_adj_t adj_r;
  logic                    capture_input_enable_r;
  logic [2:0]              filter_enable_low_r, filter_enable_high_r;
  logic [3:0]              periodic_interval_select_r;

  // bus slave state
  logic        aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0]  wstrb_r;
  logic [1:0]  rresp_r, bresp_r;
  logic        wr_fire, wr_low, wr_hit;

  assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
  assign S_AXI_WREADY  = !w_held_r && !bvalid_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RDATA   = rdata_r;
  assign S_AXI_RRESP   = rresp_r;
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  assign wr_low  = wr_fire && wstrb_r[0];

  function automatic logic wr_to(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a <= rtceac_pkg::OFS_PRESC && a[1:0] == 2'h0) ||
           (a >= rtceac_pkg::OFS_CAP_DATA0 && a < 8'h58 && a[1:0] == 2'h0);
  endfunction

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= rtceac_pkg::RESP_OKAY;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else if (CLK_EN) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_r <= 1'b1;
        wdata_r  <= S_AXI_WDATA;
        wstrb_r  <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= mapped(awaddr_r) ? rtceac_pkg::RESP_OKAY : rtceac_pkg::RESP_SLVERR;
      end else if (bvalid_r && S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // control registers; only byte lane 0 carries fields
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      auto_adjust_enable_r       <= 1'b0;
      auto_adjust_period_r       <= 1'b0;
      count_mode_select_r        <= 1'b0;
      adj_r                      <= '0;
      capture_input_enable_r     <= 1'b0;
      periodic_interval_select_r <= 4'h0;
    end else if (CLK_EN && wr_low) begin
      if (wr_to(awaddr_r, rtceac_pkg::OFS_CTRL_TWO)) begin
        auto_adjust_enable_r <= wdata_r[rtceac_pkg::BIT_AUTO_EN];  // see [RULE2]
        auto_adjust_period_r <= wdata_r[rtceac_pkg::BIT_AUTO_PER];
        count_mode_select_r  <= wdata_r[rtceac_pkg::BIT_CNT_MODE];
      end
      if (wr_to(awaddr_r, rtceac_pkg::OFS_ADJUST))
        adj_r <= wdata_r[7:0];  // see [RULE7]
      if (wr_to(awaddr_r, rtceac_pkg::OFS_CTRL_THREE))
        capture_input_enable_r <= wdata_r[0];
      if (wr_to(awaddr_r, rtceac_pkg::OFS_PERIODIC))
        periodic_interval_select_r <= wdata_r[3:0];
    end
  end

  // kept through ordinary resets
  always_ff @(posedge SYS_CLK or negedge RTC_POR_N) begin
    if (!RTC_POR_N) begin
      filter_enable_low_r  <= 3'h0;  // see [RULE22]
      filter_enable_high_r <= 3'h0;
    end else if (CLK_EN && wr_low && wr_to(awaddr_r, rtceac_pkg::OFS_FILT_EN)) begin
      filter_enable_low_r  <= wdata_r[2:0];
      filter_enable_high_r <= wdata_r[rtceac_pkg::FILT_HIGH_POS +: 3];
    end
  end

  // prescaler and time error adjustment
  logic [14:0] presc_r;
  logic [16:0] presc_sum;
  logic [14:0] presc_nxt;
  logic        second_nxt, second_r, two_sec_r;
  logic [5:0]  sec_cnt_r, period_len;
  logic        auto_due_r, sw_due_r, adj_apply, adj_active;

  assign adj_active = adj_r.direction == rtceac_pkg::DIR_ADD ||
                      adj_r.direction == rtceac_pkg::DIR_SUB;  // see [RULE6]
  // pending correction lands on the next source cycle
  assign adj_apply  = SUB_TICK && adj_active &&
                      (auto_adjust_enable_r ? auto_due_r : sw_due_r);  // see [RULE3]

  always_comb begin
    presc_sum = {2'h0, presc_r} + 17'h00001;
    if (adj_apply && adj_r.direction == rtceac_pkg::DIR_ADD)
      presc_sum = presc_sum + {11'h000, adj_r.amount};
    else if (adj_apply && adj_r.direction == rtceac_pkg::DIR_SUB)
      presc_sum = (presc_sum > {11'h000, adj_r.amount}) ?
                  presc_sum - {11'h000, adj_r.amount} : 17'h00000;
    // a subtraction never reaches back over the last boundary
    second_nxt = SUB_TICK && presc_sum >= rtceac_pkg::PRESC_CYCLES_W;  // see [RULE1]
    presc_nxt  = second_nxt ? presc_sum[14:0] : (SUB_TICK ? presc_sum[14:0] : presc_r);
  end

  always_comb begin
    if (count_mode_select_r && auto_adjust_period_r)
      period_len = rtceac_pkg::PERIOD_EIGHT;  // see [RULE5]
    else if (!count_mode_select_r && auto_adjust_period_r)
      period_len = rtceac_pkg::PERIOD_TEN_SEC;  // see [RULE4]
    else
      period_len = rtceac_pkg::PERIOD_MINUTE;
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      presc_r   <= rtceac_pkg::PRESC_RESET;
      second_r  <= 1'b0;
      two_sec_r <= 1'b0;
      sec_cnt_r <= 6'h00;
    end else if (CLK_EN) begin
      presc_r  <= presc_nxt;
      second_r <= second_nxt;
      if (second_nxt) begin
        two_sec_r <= !two_sec_r;
        sec_cnt_r <= (sec_cnt_r >= period_len - 6'h01) ? 6'h00 : sec_cnt_r + 6'h01;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      auto_due_r <= 1'b0;
      sw_due_r   <= 1'b0;
    end else if (CLK_EN) begin
      if (!auto_adjust_enable_r || !adj_active)
        auto_due_r <= 1'b0;  // see [RULE11]
      else if (second_nxt && sec_cnt_r >= period_len - 6'h01)
        auto_due_r <= 1'b1;  // see [RULE3]
      else if (adj_apply)
        auto_due_r <= 1'b0;
      // a write in the apply cycle queues one more correction
      if (wr_low && wr_to(awaddr_r, rtceac_pkg::OFS_ADJUST) && !auto_adjust_enable_r)
        sw_due_r <= wdata_r[7:6] == rtceac_pkg::DIR_ADD ||
                    wdata_r[7:6] == rtceac_pkg::DIR_SUB;  // see [RULE8] see [RULE9]
      else if (adj_apply || auto_adjust_enable_r || !adj_active)
        sw_due_r <= 1'b0;
    end
  end

  assign SECOND_PULSE = second_r;
  assign PRESC_COUNT  = presc_r;

  // capture filter sample clocks
  logic [12:0] div_r;
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N)
      div_r <= 13'h0000;
    else if (CLK_EN && SUB_TICK)
      div_r <= div_r + 13'h0001;
  end

  logic [7:0]  cap_ctrl_r   [NCAP];
  logic [39:0] cap_store_r  [NCAP];
  logic [2:0]  cap_hist_r   [NCAP];
  logic [NCAP-1:0] filt_lvl_r, cap_ev;

  for (genvar n = 0; n < NCAP; n++) begin : g_cap
    logic strobe, filt_on, legal, in_edge, lvl;
    logic [1:0] sel;
    always_comb begin
      sel     = cap_ctrl_r[n][1:0];
      strobe  = 1'b0;
      filt_on = 1'b1;
      legal   = 1'b1;
      unique case ({sel, filter_enable_high_r[n], filter_enable_low_r[n]})  // see [RULE16]
        4'b0000, 4'b0001: filt_on = 1'b0;
        4'b0010: strobe = SUB_TICK && (div_r[11:0] == rtceac_pkg::DIV_4096_MASK[11:0]);
        4'b0011: strobe = SUB_TICK && (div_r == rtceac_pkg::DIV_8192_MASK);  // see [RULE23]
        4'b1000: strobe = SUB_TICK;
        4'b1100: strobe = SUB_TICK && (div_r[4:0] == rtceac_pkg::DIV_32_MASK[4:0]);
        default: legal = 1'b0;
      endcase
      // pins are already synchronous, so the filter-off path is one flop deep
      lvl = filt_on ? filt_lvl_r[n] : cap_hist_r[n][0];  // see [RULE24]
      in_edge = filt_on ? (cap_hist_r[n][2] != filt_lvl_r[n] && cap_hist_r[n][2] ==
                cap_hist_r[n][1] && cap_hist_r[n][1] == cap_hist_r[n][0] && strobe) :
                (cap_hist_r[n][0] != cap_hist_r[n][1]);
      cap_ev[n] = capture_input_enable_r && legal && in_edge &&  // see [RULE17]
                  ((cap_ctrl_r[n][5:4] == 2'h1 && !lvl) || (cap_ctrl_r[n][5:4] == 2'h2 && lvl) ||
                   (cap_ctrl_r[n][5:4] == 2'h3));
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        cap_hist_r[n] <= 3'h0;
        filt_lvl_r[n] <= 1'b0;
      end else if (CLK_EN) begin
        if (!filt_on)
          cap_hist_r[n] <= {cap_hist_r[n][1:0], CAPTURE_EVENT_INPUT[n]};
        else if (strobe)
          cap_hist_r[n] <= {cap_hist_r[n][1:0], CAPTURE_EVENT_INPUT[n]};  // see [RULE15]
        if (filt_on && strobe && cap_hist_r[n][2] == cap_hist_r[n][1] &&
            cap_hist_r[n][1] == cap_hist_r[n][0])
          filt_lvl_r[n] <= cap_hist_r[n][2];  // see [RULE13]
      end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        cap_ctrl_r[n]  <= 8'h00;
        cap_store_r[n] <= 40'h00_0000_0000;
      end else if (CLK_EN) begin
        if (wr_low && wr_to(awaddr_r, rtceac_pkg::OFS_CAP_CTRL0 + 8'(4 * n))) begin
          cap_ctrl_r[n][5:0] <= wdata_r[5:0];
          if (!wdata_r[rtceac_pkg::BIT_CAP_STATUS])
            cap_ctrl_r[n][rtceac_pkg::BIT_CAP_STATUS] <= 1'b0;
        end
        if (cap_ev[n]) begin
          cap_ctrl_r[n][rtceac_pkg::BIT_CAP_STATUS] <= 1'b1;  // see [RULE14]
          cap_store_r[n] <= count_mode_select_r ? {8'h00, BIN_COUNT} : CAL_COUNT;  // see [RULE12]
        end
      end
    end
  end

  // alarm and periodic requests
  logic [1:0] alarm_flag_r, alarm_armed_r, alarm_set;
  logic       periodic_flag_r, periodic_set;
  logic [14:0] per_mask;

  assign alarm_set = ALARM_MATCH & alarm_armed_r;

  always_comb begin
    per_mask = 15'h7fff;
    if (periodic_interval_select_r >= rtceac_pkg::PIS_256TH &&
        periodic_interval_select_r < 4'he)
      per_mask = 15'h7fff >> (4'he - periodic_interval_select_r);
    if (periodic_interval_select_r < rtceac_pkg::PIS_256TH)
      periodic_set = 1'b0;
    else if (periodic_interval_select_r == rtceac_pkg::PIS_TWO_S)
      periodic_set = second_nxt && two_sec_r;
    else
      periodic_set = second_nxt || (SUB_TICK && ((presc_r & ~per_mask) != (presc_nxt & ~per_mask)));  // see [RULE21]
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      alarm_flag_r    <= 2'h0;
      alarm_armed_r   <= 2'h3;
      periodic_flag_r <= 1'b0;
      ALARM_IRQ       <= 2'h0;
      PERIODIC_IRQ    <= 1'b0;
    end else if (CLK_EN) begin
      ALARM_IRQ    <= alarm_set;  // see [RULE18]
      PERIODIC_IRQ <= periodic_set;
      // rearm once the match drops or the alarm is rewritten
      alarm_armed_r <= (alarm_armed_r & ~alarm_set) | ~ALARM_MATCH | ALARM_REWRITE;  // see [RULE19]
      if (wr_low && wr_to(awaddr_r, rtceac_pkg::OFS_IRQ_FLAGS)) begin
        alarm_flag_r    <= (alarm_flag_r & wdata_r[1:0]) | alarm_set;  // see [RULE20]
        periodic_flag_r <= (periodic_flag_r & wdata_r[2]) | periodic_set;
      end else begin
        alarm_flag_r    <= alarm_flag_r | alarm_set;
        periodic_flag_r <= periodic_flag_r | periodic_set;
      end
    end
  end

  // read path
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= rtceac_pkg::RESP_OKAY;
    end else if (CLK_EN) begin
      if (S_AXI_ARVALID && !rvalid_r) begin
        rvalid_r <= 1'b1;
        rresp_r  <= mapped(S_AXI_ARADDR) ? rtceac_pkg::RESP_OKAY : rtceac_pkg::RESP_SLVERR;
        rdata_r  <= 32'h0000_0000;
        unique case (S_AXI_ARADDR)
          rtceac_pkg::OFS_CTRL_TWO:
            rdata_r[2:0] <= {count_mode_select_r, auto_adjust_period_r, auto_adjust_enable_r};
          rtceac_pkg::OFS_ADJUST:     rdata_r[7:0] <= adj_r;
          rtceac_pkg::OFS_CTRL_THREE: rdata_r[0] <= capture_input_enable_r;
          rtceac_pkg::OFS_FILT_EN:    rdata_r[6:0] <= {filter_enable_high_r, 1'b0, filter_enable_low_r};
          8'h10:                      rdata_r[7:0] <= cap_ctrl_r[0];
          8'h14:                      rdata_r[7:0] <= cap_ctrl_r[1];
          8'h18:                      rdata_r[7:0] <= cap_ctrl_r[2];
          rtceac_pkg::OFS_PERIODIC:   rdata_r[3:0] <= periodic_interval_select_r;
          rtceac_pkg::OFS_IRQ_FLAGS:  rdata_r[2:0] <= {periodic_flag_r, alarm_flag_r};
          rtceac_pkg::OFS_PRESC:      rdata_r[14:0] <= presc_r;
          8'h40: rdata_r <= cap_store_r[0][31:0];
          8'h44: rdata_r[7:0] <= cap_store_r[0][39:32];
          8'h48: rdata_r <= cap_store_r[1][31:0];
          8'h4c: rdata_r[7:0] <= cap_store_r[1][39:32];
          8'h50: rdata_r <= cap_store_r[2][31:0];
          8'h54: rdata_r[7:0] <= cap_store_r[2][39:32];
          default: rdata_r <= 32'h0000_0000;
        endcase
      end else if (rvalid_r && S_AXI_RREADY) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // checks
  presc_wrap_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)  // see [RULE1]
    CLK_EN && SUB_TICK && !adj_apply && presc_r == 15'h7fff |=> SECOND_PULSE && presc_r == 15'h0000)
    else $error("prescaler did not wrap at one second");
  adj_add_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)  // see [RULE6]
    CLK_EN && adj_apply && adj_r.direction == rtceac_pkg::DIR_ADD && presc_r < 15'h4000
    |=> presc_r == $past(presc_r) + 15'h0001 + {9'h000, $past(adj_r.amount)})
    else $error("add correction wrong");
  sw_write_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)  // see [RULE8]
    CLK_EN && wr_low && wr_to(awaddr_r, rtceac_pkg::OFS_ADJUST) && !auto_adjust_enable_r &&
    wdata_r[7:6] == rtceac_pkg::DIR_SUB |=> sw_due_r)
    else $error("software correction not queued");
  adj_stop_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)  // see [RULE11]
    adj_r.direction == rtceac_pkg::DIR_NONE |-> !adj_apply)
    else $error("correction with direction none");
  cap_off_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)  // see [RULE17]
    CLK_EN && !capture_input_enable_r |=> $stable(cap_store_r[0]) && $stable(cap_store_r[1]))
    else $error("capture while input disabled");
  cap_status_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)  // see [RULE14]
    CLK_EN && cap_ev[1] |=> cap_ctrl_r[1][rtceac_pkg::BIT_CAP_STATUS])
    else $error("capture status not set");
  alarm_once_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)  // see [RULE19]
    CLK_EN && alarm_set[0] ##1 CLK_EN && ALARM_MATCH[0] && !ALARM_REWRITE[0] |-> !alarm_set[0])
    else $error("alarm set twice in one match");
  per_pulse_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)  // see [RULE21]
    CLK_EN && periodic_set |=> PERIODIC_IRQ && periodic_flag_r)
    else $error("periodic request lost");
  bresp_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped");
endmodule // rtceac_top

/* sim/rtceac_cap_src.sv */
// capture event source model driving the capture pins
`timescale 1ns/1ps
module rtceac_cap_src #(
  parameter int HOLD = 10
) (
  input  wire logic       clk,
  input  wire logic [2:0] fire,
  output logic      [2:0] pins
);
  int cnt [3] = '{0, 0, 0};
  initial pins = 3'h0;
  // a fired pin stays high for HOLD cycles, then returns to its idle low level
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (fire[i]) begin
        pins[i] <= 1'h1;
        cnt[i]  <= HOLD;
      end else if (cnt[i] > 1) begin
        cnt[i] <= cnt[i] - 1;
      end else begin
        pins[i] <= 1'h0;
      end
    end
  end
endmodule // rtceac_cap_src

/* sim/rtceac_top_bench.sv */
// bench for the rtc error adjust, capture and interrupt block
`timescale 1ns/1ps
module rtceac_top_bench;
  logic        sys_clk  = 1'h0;
  logic        reset_n  = 1'h0;
  logic        por_n    = 1'h0;
  logic        sub_tick = 1'h0;
  logic [2:0]  fire     = 3'h0;
  logic [2:0]  pins;
  logic [7:0]  awaddr   = 8'h00;
  logic [7:0]  araddr   = 8'h00;
  logic [31:0] wdata    = 32'h0;
  logic        awvalid  = 1'h0;
  logic        wvalid   = 1'h0;
  logic        bready   = 1'h0;
  logic        arvalid  = 1'h0;
  logic        rready   = 1'h0;
  logic [1:0]  alarm_m  = 2'h0;
  logic [1:0]  alarm_irq;
  logic [14:0] presc;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  int          n_errors = 0;
  int          n_tests  = 0;
  always #2.5 sys_clk = ~sys_clk;
  rtceac_cap_src i_rtceac_cap_src (.clk(sys_clk), .fire(fire), .pins(pins));
  rtceac_top i_rtceac_top (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .RTC_POR_N(por_n), .CLK_EN(1'h1),
    .SUB_TICK(sub_tick), .CAL_COUNT(40'h0312153045), .BIN_COUNT(32'hcafe0123),
    .CAPTURE_EVENT_INPUT(pins), .ALARM_MATCH(alarm_m), .ALARM_REWRITE(2'h0),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SECOND_PULSE(),
    .PRESC_COUNT(presc), .ALARM_IRQ(alarm_irq), .PERIODIC_IRQ());
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // each channel released only at the edge where it is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    forever begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    bready <= 1'h0;
  endtask
  task automatic rdx(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    forever begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    rdx(a, d, r);
    chk(what, d, exp);
  endtask
  // exactly n counting-source cycles
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk) sub_tick <= 1'h1;
    @(posedge sys_clk) sub_tick <= 1'h0;
  endtask
  task automatic pulse(input int n);
    @(posedge sys_clk) fire[n] <= 1'h1;
    @(posedge sys_clk) fire[n] <= 1'h0;
    repeat (14) @(posedge sys_clk);
  endtask
  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'h1;
    por_n   <= 1'h1;
    rc(8'h24, 32'h0, "prescaler reset");
    rc(8'h0c, 32'h0, "filter enable reset");
    rdx(8'h3c, rd, rsp);
    chk("unmapped resp", {30'h0, rsp}, {30'h0, rtceac_pkg::RESP_SLVERR});
    chk("unmapped data", rd, 32'h0);
    tick(10);
    @(negedge sys_clk) chk("prescaler port", {17'h0, presc}, 32'h0a);
    rc(8'h24, 32'h0a, "prescaler count");
    wr(8'h04, 32'h45);
    tick(1);
    rc(8'h24, 32'h10, "software add");
    wr(8'h04, 32'h45);
    tick(1);
    rc(8'h24, 32'h16, "second write adds again");
    tick(3);
    rc(8'h24, 32'h19, "no repeat without write");
    wr(8'h04, 32'h83);
    tick(1);
    rc(8'h24, 32'h17, "software subtract");
    wr(8'h04, 32'h05);
    tick(1);
    rc(8'h24, 32'h18, "direction none");
    // direction already none, so the mode may change
    wr(8'h00, 32'h01);
    wr(8'h04, 32'h45);
    tick(1);
    rc(8'h24, 32'h19, "auto mode ignores write");
    wr(8'h04, 32'h05);
    wr(8'h10, 32'h10);
    pulse(0);
    rc(8'h10, 32'h10, "capture while disabled");
    wr(8'h08, 32'h01);
    pulse(0);
    rc(8'h10, 32'h90, "capture status");
    rc(8'h40, 32'h12153045, "captured time");
    rc(8'h44, 32'h03, "captured month");
    wr(8'h00, 32'h04);
    wr(8'h18, 32'h10);
    pulse(2);
    rc(8'h50, 32'hcafe0123, "captured binary");
    rc(8'h48, 32'h0, "other channel idle");
    // two matching samples are not enough, five are
    wr(8'h14, 32'h12);
    fork
      pulse(1);
      begin repeat (3) @(posedge sys_clk); tick(2); end
    join
    rc(8'h14, 32'h12, "two samples refused");
    fork
      pulse(1);
      begin repeat (3) @(posedge sys_clk); tick(5); end
    join
    rc(8'h14, 32'h92, "filtered capture");
    @(posedge sys_clk) alarm_m <= 2'h1;
    repeat (2) @(negedge sys_clk);
    chk("alarm irq", {30'h0, alarm_irq}, 32'h1);
    rc(8'h20, 32'h1, "alarm flag");
    wr(8'h20, 32'h0);
    rc(8'h20, 32'h0, "alarm not set again");
    @(posedge sys_clk) alarm_m <= 2'h0;
    @(posedge sys_clk) alarm_m <= 2'h1;
    // 128 ticks always cross one 1/256 s boundary
    wr(8'h1c, 32'h06);
    tick(128);
    rc(8'h20, 32'h5, "new match and periodic");
    wr(8'h0c, 32'h21);
    @(posedge sys_clk) reset_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'h1;
    rc(8'h0c, 32'h21, "filter enable kept");
    rc(8'h24, 32'h0, "prescaler cleared");
    print_verdict();
  end
endmodule // rtceac_top_bench
